// ==== pchm_defines.svh ====
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Included by the miscellaneous configuration block and its arbiter gate.
// Notes:   Definitions only.
`ifndef PCHM_DEFINES_SVH
`define PCHM_DEFINES_SVH

// Register byte offsets on the APB.
`define PCHM_MISC_CONFIG_OFS  12'h00c
`define PCHM_LINK_STATUS_OFS  12'h010

// Field positions inside misc_config.
`define PCHM_TXD_IMM_BIT      0
`define PCHM_CFG_SPACE_BIT    1
`define PCHM_SEG_LSB          2
`define PCHM_RSTCTL_LSB       4
`define PCHM_GNTPOL_LSB       6
`define PCHM_GNTDLY_LSB       8
`define PCHM_CDIS_BIT         12
`define PCHM_SPILL_LSB        13
`define PCHM_OBS_LSB          16
`define PCHM_DSWAP_BIT        19
`define PCHM_PDSWAP_BIT       20

// Writable bits and reset value (spill timeout code 2).
`define PCHM_CFG_WMASK        32'h001f_ffff
`define PCHM_CFG_RESET        32'h0000_4000

// Reset pin control codes.
`define PCHM_RST_INPUT        2'h0
`define PCHM_RST_DRIVE_LOW    2'h1
`define PCHM_RST_DRIVE_HIGH   2'h2

// Grant policy codes.
`define PCHM_GNT_EARLY        2'h0
`define PCHM_GNT_FRAME        2'h1

// Spill timeouts in hclk cycles; zero means never.
`define PCHM_SPILL_T0         11'h020
`define PCHM_SPILL_T1         11'h040
`define PCHM_SPILL_T2         11'h080
`define PCHM_SPILL_T3         11'h100
`define PCHM_SPILL_T4         11'h200
`define PCHM_SPILL_T5         11'h400
`define PCHM_SPILL_T6         11'h400
`define PCHM_SPILL_NEVER      11'h000

`endif

// ==== pchm_pkg.sv ====
// Purpose: Types shared by the miscellaneous configuration block.
// Assumes: Nothing beyond the defines header.
// Notes:   The register side and the arbiter gate each keep all their state in one packed struct.
package pchm_pkg;

    // Strap capture sequence after reset release.
    typedef enum logic [1:0] {
        PCHM_BOOT_WAIT0,
        PCHM_BOOT_WAIT1,
        PCHM_BOOT_LOAD,
        PCHM_BOOT_RUN
    } pchm_boot_t;

    // State of the register side on pclk.
    typedef struct packed {
        logic [31:0] cfg;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [1:0]  rst_sync;
        logic [1:0]  strap_sync;
        logic [1:0]  ack_sync;
        logic        req_tgl;
        logic [5:0]  xfer;
        logic [10:0] idle_cnt;
        logic        spill;
        logic        rst_o;
        logic        rst_oe_n;
        pchm_boot_t  boot;
    } pchm_reg_state_t;

    // State of the arbiter gate on the link clock.
    typedef struct packed {
        logic [1:0] req_sync;
        logic       req_seen;
        logic [1:0] policy;
        logic [3:0] delay;
        logic       frame_q;
        logic [3:0] dly_cnt;
        logic       grant_ok;
    } pchm_arb_state_t;

endpackage

// ==== pchm_arb_gate.sv ====
// Purpose: Link-side gate telling the PCI arbiter when it may issue the next grant.
// Assumes: frame_n and irdy_n are synchronous to pci_clk; cfg_data is held stable
//          by the register side from its request toggle until the returned ack.
// Notes:   Policy and delay arrive through a toggle request/acknowledge handshake.
`timescale 1ns/10ps
`include "pchm_defines.svh"
module pchm_arb_gate
    import pchm_pkg::*;
(
    // Link clock and reset.
    input  wire logic       pci_clk,
    input  wire logic       presetn,
    // Configuration handshake from the register side.
    input  wire logic       cfg_req,
    input  wire logic [5:0] cfg_data,
    output logic            cfg_ack,
    // Bus observation and grant permission.
    input  wire logic       frame_n,
    input  wire logic       irdy_n,
    output logic            grant_ok
);

    pchm_arb_state_t st;
    pchm_arb_state_t next_st;
    logic            start;
    logic            idle_ok;

    // Capture new settings, time the inter-grant delay and apply the policy.
    always_comb begin
        next_st = st;
        next_st.req_sync = {st.req_sync[0], cfg_req};
        if (st.req_sync[1] != st.req_seen) begin
            next_st.req_seen = st.req_sync[1];
            next_st.policy   = cfg_data[1:0];
            next_st.delay    = cfg_data[5:2];
        end
        next_st.frame_q = frame_n;
        start = st.frame_q & ~frame_n;
        if (start) begin
            next_st.dly_cnt = st.delay;
        end else if (st.dly_cnt != 4'h0) begin
            next_st.dly_cnt = st.dly_cnt - 4'h1;
        end
        case (st.policy)
            `PCHM_GNT_EARLY: idle_ok = 1'b1;
            `PCHM_GNT_FRAME: idle_ok = frame_n;
            default:         idle_ok = frame_n & irdy_n;
        endcase
        next_st.grant_ok = idle_ok & ~start & (next_st.dly_cnt == 4'h0);
    end

    // Reset is asynchronous; the settings start as early grants with no delay.
    always_ff @(posedge pci_clk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_ack  = st.req_seen;
    assign grant_ok = st.grant_ok;

endmodule

// ==== pchm_misc_config.sv ====
// Purpose: Miscellaneous configuration register of the PCI host side, on APB.
// Assumes: pclk doubles as the AHB clock that times the write buffer spill.
// Notes:   Arbiter settings cross to pci_clk through a toggle handshake.
// Summary of operation
// - Bits 3:2 give PCI address bits 31:30 for external window accesses, reset 0.
// - Bits 5:4 make the PCI reset pin an input, drive it low or drive it high.
// - Bits 7:6 allow early grants, or hold grants for FRAME# or for an idle bus.
// - Bits 11:8 set the least cycles from a transaction start to the next grant.
// - Bit 12 disables read cache and write buffer so each access is one word.
// - The write buffer spills after the programmed idle hclk cycles, code 2 at reset.
// - Spill codes 0 to 3 mean 32, 64, 128 and 256 cycles; code 7 never spills.
// - Bits 18:16 select the observation port source, reset 0.
// - Bit 19 byte-swaps local descriptors and resets from the big-endian strap.
// - Bit 20 byte-swaps PCI path descriptors, reset 0.
// - Bit 0 chooses deferred or immediate handling of a disable in a fragment.
// - Bit 1 turns window accesses into configuration instead of memory cycles.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "pchm_defines.svh"
module pchm_misc_config
    import pchm_pkg::*;
(
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // PCI link side.
    input  wire logic        pci_clk,
    input  wire logic        pci_frame_n,
    input  wire logic        pci_irdy_n,
    output logic             grant_ok,
    // PCI reset pin, split into input, output and enable.
    input  wire logic        pci_rst_n_i,
    output logic             pci_rst_n_o,
    output logic             pci_rst_n_oe_n,
    // Strap sampled after reset.
    input  wire logic        cpu_big_endian_strap,
    // Write buffer of the external window.
    input  wire logic        wb_push,
    input  wire logic        wb_nonempty,
    output logic             wb_spill,
    // Configuration outputs.
    output logic [1:0]       pci_addr_hi,
    output logic             pci_cfg_space,
    output logic             txd_immediate,
    output logic             cache_disable,
    output logic [2:0]       obs_sel,
    output logic             desc_swap,
    output logic             pci_desc_swap
);

    pchm_reg_state_t st;
    pchm_reg_state_t next_st;
    logic            cfg_ack;
    logic            apb_access;
    logic [10:0]     limit;
    logic [5:0]      arb_cfg;
    logic [32:0]     rd;

    // Spill timeout code to cycles; a zero result means no timeout.
    // codes four to six
    function automatic logic [10:0] spill_limit(input logic [2:0] code);
        logic [10:0] r;
        case (code)
            3'h0:    r = `PCHM_SPILL_T0;
            3'h1:    r = `PCHM_SPILL_T1;
            3'h2:    r = `PCHM_SPILL_T2;
            3'h3:    r = `PCHM_SPILL_T3;
            3'h4:    r = `PCHM_SPILL_T4;
            3'h5:    r = `PCHM_SPILL_T5;
            3'h6:    r = `PCHM_SPILL_T6;
            default: r = `PCHM_SPILL_NEVER;
        endcase
        return r;
    endfunction

    // Address decode; bit 32 flags a mapped register.
    function automatic logic [32:0] reg_read(input logic [11:0]     addr,
                                             input pchm_reg_state_t s);
        logic [32:0] r;
        case (addr)
            `PCHM_MISC_CONFIG_OFS: r = {1'b1, s.cfg};
            `PCHM_LINK_STATUS_OFS: r = {1'b1, 29'h0000_0000,
                                        s.req_tgl != s.ack_sync[1],
                                        s.boot == PCHM_BOOT_RUN,
                                        s.rst_sync[1]};
            default:               r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // Arbiter gate on the link clock.
    pchm_arb_gate pchm_arb_gate_inst (
        .pci_clk  (pci_clk),
        .presetn  (presetn),
        .cfg_req  (st.req_tgl),
        .cfg_data (st.xfer),
        .cfg_ack  (cfg_ack),
        .frame_n  (pci_frame_n),
        .irdy_n   (pci_irdy_n),
        .grant_ok (grant_ok)
    );

    // Register side next state.
    always_comb begin
        next_st    = st;
        apb_access = psel & penable;
        rd         = reg_read(paddr, st);
        limit      = spill_limit(st.cfg[`PCHM_SPILL_LSB +: 3]);
        arb_cfg    = {st.cfg[`PCHM_GNTDLY_LSB +: 4], st.cfg[`PCHM_GNTPOL_LSB +: 2]};

        // Synchronisers for pins and the returning acknowledge.
        next_st.rst_sync   = {st.rst_sync[0], pci_rst_n_i};
        next_st.strap_sync = {st.strap_sync[0], cpu_big_endian_strap};
        next_st.ack_sync   = {st.ack_sync[0], cfg_ack};

        // The strap is caught only after two synchroniser stages have filled.
        case (st.boot)
            PCHM_BOOT_WAIT0: next_st.boot = PCHM_BOOT_WAIT1;
            PCHM_BOOT_WAIT1: next_st.boot = PCHM_BOOT_LOAD;
            PCHM_BOOT_LOAD: begin
                next_st.cfg[`PCHM_DSWAP_BIT] = st.strap_sync[1];
                next_st.boot = PCHM_BOOT_RUN;
            end
            PCHM_BOOT_RUN:   next_st.boot = PCHM_BOOT_RUN;
            default:         next_st.boot = PCHM_BOOT_RUN;
        endcase

        // APB answers one cycle into the access phase; the write lands with pready.
        next_st.pready  = apb_access & ~st.pready;
        next_st.pslverr = apb_access & ~st.pready & ~rd[32];
        if (apb_access & ~st.pready) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
        end
        if (apb_access & st.pready & pwrite & (paddr == `PCHM_MISC_CONFIG_OFS)) begin
            next_st.cfg = pwdata & `PCHM_CFG_WMASK;
        end

        // New arbiter settings go over only when no request is in flight.
        if ((st.req_tgl == st.ack_sync[1]) && (st.xfer != arb_cfg)) begin
            next_st.xfer    = arb_cfg;
            next_st.req_tgl = ~st.req_tgl;
        end

        case (st.cfg[`PCHM_RSTCTL_LSB +: 2])
            `PCHM_RST_DRIVE_LOW: begin
                next_st.rst_o    = 1'b0;
                next_st.rst_oe_n = 1'b0;
            end
            `PCHM_RST_DRIVE_HIGH: begin
                next_st.rst_o    = 1'b1;
                next_st.rst_oe_n = 1'b0;
            end
            default: begin
                next_st.rst_o    = 1'b0;
                next_st.rst_oe_n = 1'b1;
            end
        endcase

        next_st.spill = 1'b0;
        if (wb_push) begin
            next_st.idle_cnt = 11'h000;
            next_st.spill = st.cfg[`PCHM_CDIS_BIT];
        end else if (wb_nonempty && (limit != `PCHM_SPILL_NEVER)) begin
            if (st.idle_cnt + 11'h001 >= limit) begin
                next_st.idle_cnt = 11'h000;
                next_st.spill    = 1'b1;
            end else begin
                next_st.idle_cnt = st.idle_cnt + 11'h001;
            end
        end else begin
            next_st.idle_cnt = 11'h000;
        end
    end

    // Asynchronous reset to constants only; the strap value follows in LOAD.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.cfg      <= `PCHM_CFG_RESET;
            st.rst_oe_n <= 1'b1;
            st.boot     <= PCHM_BOOT_WAIT0;
        end else begin
            st <= next_st;
        end
    end

    // APB outputs.
    assign pready  = st.pready;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;

    // Pin and buffer outputs, all from flip-flops.
    assign pci_rst_n_o    = st.rst_o;
    assign pci_rst_n_oe_n = st.rst_oe_n;
    assign wb_spill       = st.spill;

    assign pci_addr_hi   = st.cfg[`PCHM_SEG_LSB +: 2];
    assign pci_cfg_space = st.cfg[`PCHM_CFG_SPACE_BIT];
    assign txd_immediate = st.cfg[`PCHM_TXD_IMM_BIT];
    assign cache_disable = st.cfg[`PCHM_CDIS_BIT];
    assign obs_sel       = st.cfg[`PCHM_OBS_LSB +: 3];
    assign desc_swap     = st.cfg[`PCHM_DSWAP_BIT];
    assign pci_desc_swap = st.cfg[`PCHM_PDSWAP_BIT];

endmodule

// ==== pchm_misc_config_monitor.sv ====
// Purpose: Port checker for the miscellaneous configuration block.
// Assumes: Bound to every instance of pchm_misc_config.
// Notes:   The spill code is shadowed from APB writes to time the spill pulse.
`timescale 1ns/10ps
module pchm_misc_config_monitor (
    // APB side.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // Link side and reset pin.
    input  wire logic        pci_clk,
    input  wire logic        pci_frame_n,
    input  wire logic        grant_ok,
    input  wire logic        pci_rst_n_o,
    input  wire logic        pci_rst_n_oe_n,
    // Write buffer and configuration outputs.
    input  wire logic        wb_push,
    input  wire logic        wb_nonempty,
    input  wire logic        wb_spill,
    input  wire logic        cache_disable,
    input  wire logic [1:0]  pci_addr_hi,
    input  wire logic [2:0]  obs_sel
);
    logic [2:0]  code;
    logic [10:0] cnt;
    logic [10:0] lim;
    logic        wr;

    // A completed write to misc_config, and the idle limit of the current code.
    assign wr  = psel && penable && pready && pwrite && paddr == 12'h00c;
    assign lim = code == 3'h7 ? 11'h000 : code == 3'h6 ? 11'h400 : 11'h020 << code;

    // Idle cycles restart on a push, on an empty buffer, or when the limit is hit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code <= 3'h2;
            cnt  <= 11'h000;
        end else begin
            code <= wr ? pwdata[15:13] : code;
            cnt  <= (wb_push || !wb_nonempty || cnt + 11'h001 == lim) ? 11'h000 : cnt + 11'h001;
        end
    end

    wait_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("pready missed its wait state");
    err_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("pslverr without pready");
    rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && paddr == 12'h00c |-> prdata[31:21] == 11'h000)
        else $error("reserved bits read nonzero");
    cfg_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr |=> pci_addr_hi == $past(pwdata[3:2]) && obs_sel == $past(pwdata[18:16])
        && cache_disable == $past(pwdata[12])) else $error("outputs differ from write");
    pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && pwdata[5:4] == 2'h1 |-> ##2 !pci_rst_n_oe_n && !pci_rst_n_o)
        else $error("reset pin not driven low");
    pin_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && pwdata[4] == pwdata[5] |-> ##2 pci_rst_n_oe_n) else $error("reset pin driven");
    cd_spill_a: assert property (@(posedge pclk) disable iff (!presetn)
        cache_disable && wb_push |=> wb_spill) else $error("no single-word spill");
    spill_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cache_disable && wb_nonempty && !wb_push && lim != 0 && cnt + 11'h001 == lim
        |=> wb_spill) else $error("spill timeout missed");
    grant_hold_a: assert property (@(posedge pci_clk) disable iff (!presetn)
        $fell(pci_frame_n) |=> !grant_ok) else $error("grant allowed at start");

    cover property (@(posedge pclk) wr);
    cover property (@(posedge pclk) wb_spill && !cache_disable);
    cover property (@(posedge pci_clk) !pci_frame_n && grant_ok);
endmodule

bind pchm_misc_config pchm_misc_config_monitor pchm_misc_config_monitor_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .pci_clk, .pci_frame_n, .grant_ok, .pci_rst_n_o, .pci_rst_n_oe_n,
    .wb_push, .wb_nonempty, .wb_spill, .cache_disable, .pci_addr_hi, .obs_sel
);

// ==== pchm_pci_client.sv ====
// Purpose: Behavioural PCI client and the board view of the reset pin.
// Assumes: Lines change just after pci_clk rises and are pulled up when idle.
// Notes:   Samples the grant permission mid-frame and in the wait-state tail.
`timescale 1ns/10ps
module pchm_pci_client (
    // Link clock and grant permission.
    input  wire logic pci_clk,
    input  wire logic grant_ok,
    // Reset pin drive from the host.
    input  wire logic rst_o,
    input  wire logic rst_oe_n,
    // Board level of the pin and bus lines.
    output logic      rst_pin,
    output logic      frame_n,
    output logic      irdy_n,
    // Grant permission seen during the last transaction.
    output logic      g_mid,
    output logic      g_tail
);
    // The pull-up wins whenever the host only listens.
    assign rst_pin = rst_oe_n ? 1'b1 : rst_o;

    // Both bus lines idle high through their pull-ups.
    initial begin
        frame_n = 1'b1;
        irdy_n  = 1'b1;
        g_mid   = 1'b0;
        g_tail  = 1'b0;
    end

    // early grants tolerated
    // FRAME# low for 8 cycles; IRDY# stays low 4 wait states past it.
    task automatic xfer();
        int i;
        for (i = 0; i < 14; i++) begin
            @(posedge pci_clk);
            frame_n <= (i >= 8);
            irdy_n  <= (i < 1) || (i >= 12);
            if (i == 5)
                g_mid <= grant_ok;
            if (i == 11)
                g_tail <= grant_ok;
        end
    endtask
endmodule

// ==== pchm_misc_config_test.sv ====
// Purpose: Self-checking bench for the miscellaneous configuration block.
// Assumes: The strap is high at the first reset and low at the second.
// Notes:   Spill timing is counted in whole pclk cycles after the push.
`timescale 1ns/10ps
module pchm_misc_config_test;
    logic        pclk        = 1'b0;
    logic        pci_clk     = 1'b0;
    logic        presetn     = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic        wb_push     = 1'b0;
    logic        wb_nonempty = 1'b0;
    logic        strap       = 1'b1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [1:0]  pci_addr_hi;
    logic [2:0]  obs_sel;
    logic [10:0] outs;
    logic        pready, pslverr, grant_ok, wb_spill, er, g_mid, g_tail;
    logic        frame_n, irdy_n, rst_o, rst_oe_n, rst_pin, cache_disable;
    logic        pci_cfg_space, txd_immediate, desc_swap, pci_desc_swap;
    logic [7:0]  gt [5] = '{8'hc0, 8'h0f, 8'h50, 8'h20, 8'h30};
    int          num_errors  = 0;
    int          comparisons = 0;
    int          i;
    int          n;

    always #10 pclk = ~pclk;
    always #7.5 pci_clk = ~pci_clk;
    assign outs = {pci_addr_hi, pci_cfg_space, txd_immediate, cache_disable, obs_sel,
                   desc_swap, pci_desc_swap, rst_oe_n};

    pchm_misc_config pchm_misc_config_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
        .pslverr, .pci_clk, .pci_frame_n(frame_n), .pci_irdy_n(irdy_n), .grant_ok,
        .pci_rst_n_i(rst_pin), .pci_rst_n_o(rst_o), .pci_rst_n_oe_n(rst_oe_n),
        .cpu_big_endian_strap(strap), .wb_push, .wb_nonempty, .wb_spill, .pci_addr_hi,
        .pci_cfg_space, .txd_immediate, .cache_disable, .obs_sel, .desc_swap, .pci_desc_swap
    );
    pchm_pci_client pchm_pci_client_inst (
        .pci_clk, .grant_ok, .rst_o, .rst_oe_n, .rst_pin, .frame_n, .irdy_n, .g_mid, .g_tail
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask

    // Main sequence: reset, register image, pin, spill and grant behaviour.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        chk("reset", rd, 32'h0008_4000);
        chk("outs0", {21'h0, outs}, 32'h005);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        apb(1'b0, 12'h00c, 32'h0);
        chk("ones", rd, 32'h001f_ffff);
        chk("outs1", {21'h0, outs}, 32'h7ff);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h00c, 32'h0000_4000 | (i << 4));
            repeat (3) @(negedge pclk);
            chk("pin", {30'h0, rst_oe_n, rst_pin}, i == 1 ? 0 : i == 2 ? 1 : 3);
            // The status word shows the synchronised pin level and the finished strap capture.
            apb(1'b0, 12'h010, 32'h0);
            chk("pin_seen", {30'h0, rd[1:0]}, i == 1 ? 2 : 3);
        end
        apb(1'b1, 12'h00c, 32'h0000_5000);
        wb_push <= 1'b1;
        @(posedge pclk);
        wb_push <= 1'b0;
        @(negedge pclk);
        chk("cd_spill", {31'h0, wb_spill}, 32'h1);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, 12'h00c, i << 13);
            wb_nonempty <= 1'b1;
            @(posedge pclk);
            wb_push <= 1'b1;
            @(posedge pclk);
            wb_push <= 1'b0;
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (wb_spill !== 1'b1 && n < 1100);
            wb_nonempty <= 1'b0;
            chk("spill", n, i == 7 ? 1100 : i == 6 ? 1025 : (32 << i) + 1);
        end
        for (i = 0; i < 5; i++) begin
            apb(1'b1, 12'h00c, {20'h0, gt[i][3:0], gt[i][5:4], 6'h0});
            n = 0;
            do begin
                apb(1'b0, 12'h010, 32'h0);
                n++;
            end while (rd[2] !== 1'b0 && n < 20);
            chk("in_flight", {31'h0, rd[2]}, 32'h0);
            pchm_pci_client_inst.xfer();
            chk("grant", {30'h0, g_mid, g_tail}, {30'h0, gt[i][7:6]});
        end
        // Second reset in mid-run with the strap low: bit 19 must follow it.
        strap <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        chk("reset2", rd, 32'h0000_4000);
        final_report();
    end
endmodule
